// File: himsel_top.v
// Host interface mode select: pin sharing, FIFO strap, serial capture
`timescale 1ns/1ps
`include "himsel_defs.vh"
`default_nettype none
module himsel_top #(
	parameter SHIFT_W = `HIMSEL_SHIFT_W
) (
	// Clock and reset
	input wire clk_i,
	input wire sys_rst_i,
	// Clear request from the device core, same clock
	input wire clear_i,
	// Mode and strap pins
	input wire serial_parallel_select_i,
	input wire queue_enable_i,
	// Multifunction pins
	input wire data_bit_nine_pin_i,
	input wire data_bit_ten_pin_i,
	input wire data_bit_eleven_pin_i,
	input wire data_bit_twelve_pin_i,
	// Readback data for the serial output, same clock
	input wire [SHIFT_W-1:0] readback_data_i,
	input wire readback_load_i,
	// Open-drain SDA drive, enable low while pulling low
	input wire i2c_sda_pull_i,
	output reg sda_o,
	output reg sda_oe_n_o,
	// Mode and FIFO status
	output reg [1:0] mode_o,
	output reg fifo_enable_o,
	// Parallel data bits nine to eleven
	output reg [2:0] par_bits_o,
	// Serial capture and readback
	output reg [SHIFT_W-1:0] spi_shift_o,
	output reg spi_bit_o,
	output reg serial_readback_output_o,
	// I2C clock and data for the protocol engine
	output reg i2c_scl_o,
	output reg i2c_sda_o,
	output reg i2c_scl_fall_o
);
	wire [4:0] pins_raw;
	wire [4:0] pins_s;
	reg [1:0] mode_d;
	reg [2:0] settle_q;
	reg b12_prev_q;
	reg [SHIFT_W-1:0] rb_q;
	wire spi_mode;
	wire i2c_mode;
	wire b12_fall;
	wire b12_rise;

	assign pins_raw = {queue_enable_i, data_bit_twelve_pin_i,
		data_bit_eleven_pin_i, data_bit_ten_pin_i, data_bit_nine_pin_i};

	genvar gi;
	generate
		for (gi = 0; gi < 5; gi = gi + 1) begin : g_sync
			// Bit twelve resets to its idle high level: no false edge
			himsel_sync #(
				.RST_VAL(gi == 3)
			) u_sync (
				.clk_i(clk_i),
				.sys_rst_i(sys_rst_i),
				.pin_i(pins_raw[gi]),
				.level_o(pins_s[gi])
			);
		end
	endgenerate

	// Select line is a static strap; one extra sync for it
	wire sel_s;
	himsel_sync #(
		.RST_VAL(1'b0)
	) u_sel (
		.clk_i(clk_i),
		.sys_rst_i(sys_rst_i),
		.pin_i(serial_parallel_select_i),
		.level_o(sel_s)
	);

	always @* begin
		if (!sel_s) begin
			mode_d = `HIMSEL_MODE_PAR;
		end else if (!pins_s[0]) begin
			mode_d = `HIMSEL_MODE_SPI;
		end else begin
			mode_d = `HIMSEL_MODE_I2C;
		end
	end

	assign spi_mode = (mode_o == `HIMSEL_MODE_SPI);
	assign i2c_mode = (mode_o == `HIMSEL_MODE_I2C);
	assign b12_fall = b12_prev_q & ~pins_s[3];
	assign b12_rise = ~b12_prev_q & pins_s[3];

	// Mode and strap are latched after reset; mode pins are expected
	// static outside reset, so the latch is only refreshed on clear.
	// Synchronisers restart with reset, so wait until their level is valid
	always @(posedge clk_i) begin
		if (sys_rst_i) begin
			mode_o <= `HIMSEL_MODE_PAR;
			fifo_enable_o <= 1'b0;
			settle_q <= `HIMSEL_SETTLE_CYC;
		end else begin
			if (clear_i) begin
				settle_q <= `HIMSEL_SETTLE_CYC;
			end else if (settle_q != 3'h0) begin
				settle_q <= settle_q - 3'h1;
				if (settle_q == 3'h1) begin
					mode_o <= mode_d;
					fifo_enable_o <= pins_s[4] &
						(mode_d == `HIMSEL_MODE_PAR);
				end
			end
		end
	end

	always @(posedge clk_i) begin
		if (sys_rst_i) begin
			par_bits_o <= 3'h0;
		end else if (mode_o == `HIMSEL_MODE_PAR) begin
			par_bits_o <= pins_s[2:0];
		end
	end

	// SCLK is sampled; 50 MHz needs a faster sampling clock than here
	always @(posedge clk_i) begin
		if (sys_rst_i) begin
			b12_prev_q <= 1'b1;
			spi_shift_o <= {SHIFT_W{1'b0}};
			spi_bit_o <= 1'b0;
			rb_q <= {SHIFT_W{1'b0}};
			serial_readback_output_o <= 1'b0;
		end else begin
			b12_prev_q <= pins_s[3];
			spi_bit_o <= 1'b0;
			if (spi_mode && b12_fall) begin
				spi_shift_o <= {spi_shift_o[SHIFT_W-2:0], pins_s[2]};
				spi_bit_o <= 1'b1;
			end
			if (readback_load_i) begin
				rb_q <= readback_data_i;
			end else if (spi_mode && b12_rise) begin
				serial_readback_output_o <= rb_q[SHIFT_W-1];
				rb_q <= {rb_q[SHIFT_W-2:0], 1'b0};
			end
		end
	end

	// I2C lines at 100 or 400 kHz are far below the sampling rate
	always @(posedge clk_i) begin
		if (sys_rst_i) begin
			i2c_scl_o <= 1'b1;
			i2c_sda_o <= 1'b1;
			i2c_scl_fall_o <= 1'b0;
			sda_o <= 1'b0;
			sda_oe_n_o <= 1'b1;
		end else begin
			i2c_scl_o <= i2c_mode ? pins_s[3] : 1'b1;
			i2c_sda_o <= i2c_mode ? pins_s[2] : 1'b1;
			i2c_scl_fall_o <= i2c_mode & b12_fall;
			sda_o <= 1'b0;
			sda_oe_n_o <= ~(i2c_mode & i2c_sda_pull_i);
		end
	end
endmodule
`default_nettype wire

// File: himsel_defs.vh
// Constants for the host interface mode select block
`ifndef HIMSEL_DEFS_VH
`define HIMSEL_DEFS_VH
`define HIMSEL_MODE_PAR 2'h0
`define HIMSEL_MODE_SPI 2'h1
`define HIMSEL_MODE_I2C 2'h2
`define HIMSEL_SHIFT_W 24
`define HIMSEL_SETTLE_CYC 3'h6
`define HIMSEL_CLK_MHZ 25
`define HIMSEL_SPI_MAX_MHZ 50
`define HIMSEL_I2C_STD_KHZ 100
`define HIMSEL_I2C_FAST_KHZ 400
`endif

// File: himsel_sync.v
// Three-flop pin synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module himsel_sync #(
	parameter RST_VAL = 1'b0
) (
	// Clock and reset
	input wire clk_i,
	input wire sys_rst_i,
	// Pin and filtered level
	input wire pin_i,
	output reg level_o
);
	reg s1_q;
	reg s2_q;
	reg s3_q;
	always @(posedge clk_i) begin
		if (sys_rst_i) begin
			s1_q <= RST_VAL;
			s2_q <= RST_VAL;
			s3_q <= RST_VAL;
			level_o <= RST_VAL;
		end else begin
			s1_q <= pin_i;
			s2_q <= s1_q;
			s3_q <= s2_q;
			// Change accepted only once stages two and three agree
			if (s2_q == s3_q) begin
				level_o <= s3_q;
			end
		end
	end
endmodule
`default_nettype wire

// File: himsel_props.sv
// Mode select checker
`timescale 1ns/1ps
`default_nettype none
module himsel_props (
	input wire logic clk_i, sys_rst_i, clear_i, i2c_sda_pull_i, sda_o,
	input wire logic sda_oe_n_o, fifo_enable_o, spi_bit_o,
	input wire logic [1:0] mode_o
);
	logic [2:0] quiet_q;
	default clocking @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);
	always @(posedge clk_i)
		quiet_q <= (sys_rst_i | clear_i) ? 3'h0 :
			quiet_q + {2'h0, quiet_q != 3'h7};
	a_sda_low: assert property (!sda_o)
		else $error("sda high");
	a_pull_i2c: assert property (!sda_oe_n_o |-> mode_o == 2'h2)
		else $error("pull off i2c");
	a_pull_follow: assert property (i2c_sda_pull_i && mode_o == 2'h2 |->
		##[1:2] !sda_oe_n_o) else $error("pull lost");
	a_fifo_par: assert property (fifo_enable_o |-> mode_o == 2'h0)
		else $error("fifo off parallel");
	a_mode_held: assert property (quiet_q == 3'h7 |->
		$stable({mode_o, fifo_enable_o})) else $error("mode moved");
	a_mode_legal: assert property (mode_o != 2'h3)
		else $error("bad mode");
	a_spi_mode: assert property (spi_bit_o |-> mode_o == 2'h1)
		else $error("bit off spi");
	a_spi_pulse: assert property (spi_bit_o |=> !spi_bit_o[*3])
		else $error("bit pulse long");
	cover property (spi_bit_o);
	cover property (fifo_enable_o);
	cover property (!sda_oe_n_o);
endmodule
bind himsel_top himsel_props u_props (.clk_i, .sys_rst_i, .clear_i,
	.i2c_sda_pull_i, .sda_o, .sda_oe_n_o, .fifo_enable_o, .spi_bit_o, .mode_o);
`default_nettype wire

// File: himsel_host.sv
// Host model on the serial pins
`timescale 1ns/1ps
`default_nettype none
module himsel_host (
	input wire logic clk_i,
	output logic sclk_o = 1'h1,
	output logic din_o = 1'h1
);
	// Data changes with the rising clock, four cycles before the fall
	task automatic send(input logic [7:0] v);
		for (int i = 7; i >= 0; i--) begin
			@(posedge clk_i);
			din_o <= v[i];
			repeat (4) @(posedge clk_i);
			sclk_o <= 1'h0;
			repeat (4) @(posedge clk_i);
			sclk_o <= 1'h1;
		end
		@(posedge clk_i);
		din_o <= ~din_o; // Stale bit must not pass for data
	endtask
endmodule
`default_nettype wire

// File: host_interface_mode_select_tb_top.sv
// Mode select bench
`timescale 1ns/1ps
`default_nettype none
module host_interface_mode_select_tb_top;
	logic clk_i = 1'h0, rst = 1'h1, clr = 1'h0, qen = 1'h0, ser = 1'h0;
	logic pull = 1'h0, sda, oe_n, sck, din, fifo;
	logic [1:0] mode;
	logic [2:0] pb = 3'h4, par;
	logic [23:0] sh;
	int error_cnt = 0, tests_run = 0;
	always #20 clk_i = ~clk_i;
	himsel_host u_host (.clk_i, .sclk_o(sck), .din_o(din));
	himsel_top dut (.clk_i, .sys_rst_i(rst), .clear_i(clr), .queue_enable_i(qen),
		.serial_parallel_select_i(ser), .data_bit_nine_pin_i(pb[0]),
		.data_bit_ten_pin_i(pb[1]), .data_bit_eleven_pin_i(pb[2] & din & oe_n),
		.data_bit_twelve_pin_i(sck), .readback_data_i(24'h0),
		.readback_load_i(1'h0), .i2c_sda_pull_i(pull), .sda_o(sda),
		.sda_oe_n_o(oe_n), .mode_o(mode), .fifo_enable_o(fifo), .par_bits_o(par),
		.spi_shift_o(sh), .spi_bit_o(), .serial_readback_output_o(),
		.i2c_scl_o(), .i2c_sda_o(), .i2c_scl_fall_o());
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_i);
		@(negedge clk_i);
	endtask
	task automatic chk(input logic [11:0] got, exp);
		tests_run++;
		if (got !== exp) begin
			error_cnt++;
			$display("CHECK FAILED %0t got %h want %h", $time, got, exp);
		end
	endtask
	task automatic reset(input logic s, n, q);
		@(posedge clk_i) rst <= 1'h1;
		{ser, pb[0], qen} <= {s, n, q};
		repeat (6) @(posedge clk_i);
		rst <= 1'h0;
		cyc(4);
	endtask
	task automatic t_par;
		reset(1'h0, 1'h0, 1'h1);
		@(posedge clk_i) {pb, qen} <= 4'hC;
		cyc(8);
		chk({fifo, par}, 12'hE);
		@(posedge clk_i) clr <= 1'h1;
		@(posedge clk_i) clr <= 1'h0;
		cyc(8);
		chk(fifo, 12'h0);
		$display("par end");
	endtask
	task automatic t_spi;
		reset(1'h1, 1'h0, 1'h1);
		u_host.send(8'hC5);
		cyc(8);
		chk({fifo, mode, sh[7:0]}, 12'h1C5);
		$display("spi end");
	endtask
	task automatic t_i2c;
		reset(1'h1, 1'h1, 1'h0);
		@(posedge clk_i) pull <= 1'h1;
		cyc(3);
		chk({mode, sda, oe_n}, 12'h8);
		@(posedge clk_i) pull <= 1'h0;
		$display("i2c end");
	endtask
	task automatic end_of_test;
		$display("checks %0d mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	initial begin
		t_par;
		t_spi;
		t_i2c;
		end_of_test;
	end
	initial begin
		#60000;
		error_cnt++;
		end_of_test;
	end
endmodule
`default_nettype wire
